/* hdl/pchb_map.svh */
// Purpose: constants for the card-side host bus control and its host end
// Assumes: 50 MHz sys_clk_i, all pins synchronous to it
// Notes: times in ns, reset count derived from them; load and wait counts given in cycles
// Notes on behaviour
// - host read data driven once wait ends, while output enable or io read asserted
// - card enables steer upper and lower byte lanes
// - register select picks attribute/io versus common memory
// - sixteen-bit io flag asserted on decoded io access
// - input acknowledge only on selected io read
// - wait asserted until access done; host extends
// - valid reset starts load and full initialisation
// - reset counts only if at least 500 ns
// - interrupt request low while auto-load runs
`ifndef PCHB_MAP_SVH
`define PCHB_MAP_SVH
`define PCHB_CLK_PERIOD_NS   20
`define PCHB_RST_MIN_NS      500
`define PCHB_RST_MIN_CYC     ((`PCHB_RST_MIN_NS + `PCHB_CLK_PERIOD_NS - 1) / `PCHB_CLK_PERIOD_NS)
`define PCHB_LOAD_CYC        64
`define PCHB_WAIT_CYC        2
`define PCHB_CNT_W           8
`endif

/* hdl/pchb_pkg.sv */
package pchb_pkg;
   typedef enum logic [1:0] {PCHB_SPACE_NONE, PCHB_SPACE_COMMON, PCHB_SPACE_ATTR, PCHB_SPACE_IO} pchb_space_type;
   typedef enum {PCHB_INIT, PCHB_IDLE, PCHB_BUSY, PCHB_DONE} pchb_state_type;
   typedef enum {PCHB_H_IDLE, PCHB_H_STROBE, PCHB_H_END} pchb_hstate_type;
endpackage

/* hdl/pchb_if.sv */
// Purpose: host bus wires between socket controller and card
// Assumes: data bus kept as separate host and card directions, each qualified by its enables
// Notes: all strobes active low
`timescale 1ns/10ps
interface pchb_if;
   logic [16:0] addr;
   logic [15:0] hd_host;         // host-driven data
   logic        hd_host_oe;
   logic [15:0] hd_card;         // card-driven data
   logic        hd_card_oe_hi;
   logic        hd_card_oe_lo;
   logic        ce1_n, ce2_n, reg_n, oe_n, we_n, iord_n, iowr_n, reset;
   logic        iois16_n, inpack_n, wait_n, host_interrupt_request;
   modport card (input addr, hd_host, hd_host_oe, ce1_n, ce2_n, reg_n, oe_n, we_n, iord_n, iowr_n, reset,
                 output hd_card, hd_card_oe_hi, hd_card_oe_lo, iois16_n, inpack_n, wait_n, host_interrupt_request);
   modport host (output addr, hd_host, hd_host_oe, ce1_n, ce2_n, reg_n, oe_n, we_n, iord_n, iowr_n, reset,
                 input hd_card, hd_card_oe_hi, hd_card_oe_lo, iois16_n, inpack_n, wait_n, host_interrupt_request);
endinterface

/* hdl/pchb_card.sv */
// Purpose: card end of host bus: lane steering, space select, io flags, wait, reset
// Assumes: user side answers accesses with a ready ack, taken only once the fixed wait has run
// Notes: host read data registered; user address, write data and read strobe combinational, write strobe registered
`timescale 1ns/10ps
`include "pchb_map.svh"
module pchb_card
   import pchb_pkg::*;
(
   input  wire logic        sys_clk_i,      // system clock
   input  wire logic        nrst_i,         // async reset, low
   pchb_if.card             bus,            // host bus
   output logic [16:0]      usr_addr_o,     // access address
   output pchb_space_type   usr_space_o,    // selected space
   output logic             usr_rd_o,       // read in progress
   output logic             usr_wr_o,       // write strobe pulse
   output logic [15:0]      usr_wdata_o,    // write data
   input  wire logic [15:0] usr_rdata_i,    // read data
   input  wire logic        usr_ready_i,    // access may finish
   output logic             usr_init_o,     // initialise internal state, pulse
   output logic             usr_loading_o,  // auto-load running
   input  wire logic        usr_load_done_i // auto-load finished early
);
   typedef struct packed {
      pchb_state_type        st;
      logic [`PCHB_CNT_W-1:0] rst_cnt;
      logic [`PCHB_CNT_W-1:0] cnt;
      logic [15:0]           rdata;
      logic                  wr_seen;
      logic                  wr;
      logic                  init;
      logic                  loading;
   } pchb_card_type;

   pchb_card_type s_r, s_nxt;
   logic sel, io_acc, mem_rd, any_acc, strobe_wr;

   // deselect when both enables high
   assign sel      = !(bus.ce1_n && bus.ce2_n);
   // reg low selects attribute or io; io decided by io strobes
   assign io_acc   = sel && !bus.reg_n && (!bus.iord_n || !bus.iowr_n);
   assign mem_rd   = sel && !bus.oe_n && bus.iord_n;
   assign strobe_wr = sel && (!bus.we_n || !bus.iowr_n);
   assign any_acc  = sel && !s_r.loading && (mem_rd || !bus.iord_n || strobe_wr);

   always_comb begin
      s_nxt = s_r;
      s_nxt.wr   = 1'b0;
      s_nxt.init = 1'b0;
      // count reset high time; short glitches ignored
      if (bus.reset) begin
         if (s_r.rst_cnt != `PCHB_CNT_W'(`PCHB_RST_MIN_CYC)) begin
            s_nxt.rst_cnt = s_r.rst_cnt + `PCHB_CNT_W'(1);
         end
      end else begin
         s_nxt.rst_cnt = '0;
         if (s_r.rst_cnt == `PCHB_CNT_W'(`PCHB_RST_MIN_CYC)) begin
            s_nxt.st      = PCHB_INIT;
            s_nxt.init    = 1'b1;
            s_nxt.loading = 1'b1;
            s_nxt.cnt     = '0;
         end
      end
      unique case (s_r.st)
         PCHB_INIT: begin
            s_nxt.cnt = s_r.cnt + `PCHB_CNT_W'(1);
            if (usr_load_done_i || s_r.cnt == `PCHB_CNT_W'(`PCHB_LOAD_CYC - 1)) begin
               s_nxt.loading = 1'b0;
               s_nxt.st      = PCHB_IDLE;
            end
         end
         PCHB_IDLE: begin
            if (any_acc) begin
               s_nxt.st  = PCHB_BUSY;
               s_nxt.cnt = '0;
            end
         end
         PCHB_BUSY: begin
            if (!any_acc) begin
               s_nxt.st = PCHB_IDLE;
            end else begin
               if (s_r.cnt != `PCHB_CNT_W'(`PCHB_WAIT_CYC)) begin
                  s_nxt.cnt = s_r.cnt + `PCHB_CNT_W'(1);
               end
               if (usr_ready_i && s_r.cnt == `PCHB_CNT_W'(`PCHB_WAIT_CYC)) begin
                  s_nxt.rdata = usr_rdata_i;
                  s_nxt.st    = PCHB_DONE;
                  if (strobe_wr) begin
                     s_nxt.wr = 1'b1;
                  end
               end
            end
         end
         PCHB_DONE: begin
            if (!any_acc) begin
               s_nxt.st = PCHB_IDLE;
            end
         end
      endcase
      // a pulse still under the minimum width leaves the card running
      if (bus.reset && s_r.rst_cnt == `PCHB_CNT_W'(`PCHB_RST_MIN_CYC)) begin
         s_nxt.st      = PCHB_INIT;
         s_nxt.loading = 1'b1;
         s_nxt.cnt     = '0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_r <= '{st: PCHB_INIT, loading: 1'b1, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus.hd_card       = s_r.rdata;
   // lane enables straight from card enables; only valid data after wait ends
   assign bus.hd_card_oe_hi = !bus.ce2_n && s_r.st == PCHB_DONE && (mem_rd || (io_acc && !bus.iord_n));
   assign bus.hd_card_oe_lo = !bus.ce1_n && s_r.st == PCHB_DONE && (mem_rd || (io_acc && !bus.iord_n));
   assign bus.iois16_n      = !(io_acc && !s_r.loading);
   assign bus.inpack_n      = !(io_acc && !bus.iord_n && !s_r.loading);
   // wait until the user ack lands; host holds strobes meanwhile
   assign bus.wait_n        = !(any_acc && s_r.st != PCHB_DONE);
   assign bus.host_interrupt_request = !s_r.loading;

   assign usr_addr_o    = bus.addr;
   assign usr_space_o   = !sel ? PCHB_SPACE_NONE : bus.reg_n ? PCHB_SPACE_COMMON :
                          (!bus.iord_n || !bus.iowr_n) ? PCHB_SPACE_IO : PCHB_SPACE_ATTR;
   assign usr_rd_o      = any_acc && !strobe_wr;
   assign usr_wr_o      = s_r.wr;
   assign usr_wdata_o   = bus.hd_host_oe ? bus.hd_host : 16'h0000;
   assign usr_init_o    = s_r.init;
   assign usr_loading_o = s_r.loading;
endmodule // pchb_card

/* hdl/pchb_host.sv */
// Purpose: host socket end: runs one access per command, honours wait
// Assumes: command held until done pulse
// Notes: reset pulse stretched to one cycle past the minimum width
`timescale 1ns/10ps
`include "pchb_map.svh"
module pchb_host
   import pchb_pkg::*;
(
   input  wire logic        sys_clk_i,   // system clock
   input  wire logic        nrst_i,      // async reset, low
   pchb_if.host             bus,         // host bus
   input  wire logic        cmd_vld_i,   // start access
   input  wire logic        cmd_wr_i,    // write when high
   input  wire logic        cmd_io_i,    // io space
   input  wire logic        cmd_attr_i,  // attribute memory
   input  wire logic [1:0]  cmd_lane_i,  // bit1 upper, bit0 lower
   input  wire logic [16:0] cmd_addr_i,  // address
   input  wire logic [15:0] cmd_wdata_i, // write data
   input  wire logic        card_rst_i,  // request card reset, pulse
   output logic             cmd_rdy_o,   // idle, may accept
   output logic             done_o,      // access done, pulse
   output logic [15:0]      rdata_o,     // read data
   output logic             card_busy_o  // card still loading
);
   typedef struct packed {
      pchb_hstate_type        st;
      logic [`PCHB_CNT_W-1:0] rcnt;
      logic [16:0]            addr;
      logic [15:0]            wdata;
      logic [15:0]            rdata;
      logic                   wr, io, attr, done;
      logic [1:0]             lane;
   } pchb_host_type;

   pchb_host_type s_r, s_nxt;
   logic act;

   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (card_rst_i) begin
         s_nxt.rcnt = `PCHB_CNT_W'(`PCHB_RST_MIN_CYC + 1);
      end else if (s_r.rcnt != '0) begin
         s_nxt.rcnt = s_r.rcnt - `PCHB_CNT_W'(1);
      end
      unique case (s_r.st)
         PCHB_H_IDLE: begin
            if (cmd_vld_i && s_r.rcnt == '0) begin
               s_nxt.st = PCHB_H_STROBE;
               s_nxt.addr = cmd_addr_i;
               s_nxt.wdata = cmd_wdata_i;
               s_nxt.wr = cmd_wr_i;
               s_nxt.io = cmd_io_i;
               s_nxt.attr = cmd_attr_i;
               s_nxt.lane = cmd_lane_i;
            end
         end
         PCHB_H_STROBE: begin
            // extend the cycle while wait is asserted
            if (bus.wait_n) begin
               s_nxt.st = PCHB_H_END;
               // an undriven lane reads as zero
               s_nxt.rdata = {bus.hd_card_oe_hi ? bus.hd_card[15:8] : 8'h00,
                              bus.hd_card_oe_lo ? bus.hd_card[7:0] : 8'h00};
            end
         end
         PCHB_H_END: begin
            s_nxt.st = PCHB_H_IDLE;
            s_nxt.done = 1'b1;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_r <= '{st: PCHB_H_IDLE, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign act            = s_r.st == PCHB_H_STROBE;
   assign bus.addr       = s_r.addr;
   assign bus.hd_host    = s_r.wdata;
   assign bus.hd_host_oe = act && s_r.wr;
   assign bus.ce1_n      = !(act && s_r.lane[0]);
   assign bus.ce2_n      = !(act && s_r.lane[1]);
   assign bus.reg_n      = !(s_r.io || s_r.attr);
   assign bus.oe_n       = !(act && !s_r.wr && !s_r.io);
   assign bus.we_n       = !(act && s_r.wr && !s_r.io);
   assign bus.iord_n     = !(act && !s_r.wr && s_r.io);
   assign bus.iowr_n     = !(act && s_r.wr && s_r.io);
   assign bus.reset      = s_r.rcnt != '0;
   assign cmd_rdy_o      = s_r.st == PCHB_H_IDLE && s_r.rcnt == '0;
   assign done_o         = s_r.done;
   assign rdata_o        = s_r.rdata;
   assign card_busy_o    = !bus.host_interrupt_request;
endmodule // pchb_host

/* tb/pchb_sva.sv */
// Purpose: interface checks for the card and host ends
// Assumes: one clock, async active-low reset
// Notes: sees only interface wires
`timescale 1ns/10ps
module pchb_sva (
   input wire logic sys_clk_i, nrst_i,           // clock, reset
   input wire logic ce1_n, ce2_n, reg_n, oe_n,   // selects
   input wire logic we_n, iord_n, iowr_n, reset, // strobes
   input wire logic iois16_n, inpack_n, wait_n,  // card answers
   input wire logic host_interrupt_request,      // ready/busy
   input wire logic hd_card_oe_hi, hd_card_oe_lo // lane enables
);
   logic [7:0] rst_cnt_r;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   // saturates so a long reset never wraps back into the short range
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_cnt_r <= 8'h00;
      end else begin
         rst_cnt_r <= !reset ? 8'h00 : (rst_cnt_r == 8'hFF ? rst_cnt_r : rst_cnt_r + 8'h01);
      end
   end
   sequence s_strobe; !oe_n || !we_n || !iord_n || !iowr_n; endsequence
   sequence s_quiet; wait_n && inpack_n && iois16_n && !hd_card_oe_hi && !hd_card_oe_lo; endsequence
   property p_deselect; ce1_n && ce2_n |-> s_quiet; endproperty
   a_deselect: assert property (p_deselect) else $error("card answered while deselected");
   property p_lanes; (!hd_card_oe_hi || !ce2_n) && (!hd_card_oe_lo || !ce1_n); endproperty
   a_lanes: assert property (p_lanes) else $error("lane driven without its enable");
   property p_inpack; !inpack_n |-> !iord_n && !reg_n && !(ce1_n && ce2_n); endproperty
   a_inpack: assert property (p_inpack) else $error("input ack outside io read");
   property p_io16; !iois16_n |-> !reg_n && (!iord_n || !iowr_n); endproperty
   a_io16: assert property (p_io16) else $error("wide io flag outside io access");
   property p_read; $rose(wait_n) && !oe_n && !ce1_n |-> hd_card_oe_lo; endproperty
   a_read: assert property (p_read) else $error("read data not driven");
   property p_read_hi; $rose(wait_n) && (!oe_n || !iord_n) && !ce2_n |-> hd_card_oe_hi; endproperty
   a_read_hi: assert property (p_read_hi) else $error("upper lane not driven on read");
   property p_wait_min; $fell(wait_n) |-> !wait_n [*3]; endproperty
   a_wait_min: assert property (p_wait_min) else $error("wait too short");
   property p_wait_end; $fell(wait_n) |-> ##[3:60] wait_n; endproperty
   a_wait_end: assert property (p_wait_end) else $error("wait never ends");
   property p_host_hold; !wait_n |=> s_strobe; endproperty
   a_host_hold: assert property (p_host_hold) else $error("host ended cycle under wait");
   property p_short_rst; reset && rst_cnt_r < 8'h14 && host_interrupt_request |=> host_interrupt_request; endproperty
   a_short_rst: assert property (p_short_rst) else $error("short reset accepted");
   property p_long_rst; rst_cnt_r > 8'h19 |-> !host_interrupt_request; endproperty
   a_long_rst: assert property (p_long_rst) else $error("long reset ignored");
   property p_load_end; $fell(host_interrupt_request) |-> ##[1:120] host_interrupt_request; endproperty
   a_load_end: assert property (p_load_end) else $error("load never finishes");
endmodule // pchb_sva

/* tb/pc_card_host_bus_control_bench.sv */
// Purpose: random and corner accesses across host and card ends
// Assumes: 50 MHz clock, card reset requested from the host end
// Notes: undriven lanes are masked out of data compares
`timescale 1ns/10ps
module pc_card_host_bus_control_bench;
   import pchb_pkg::*;
   logic           sys_clk_i, nrst_i, cmd_vld_i, cmd_wr_i, cmd_io_i, cmd_attr_i, card_rst_i, usr_ready_i;
   logic [1:0]     cmd_lane_i;
   logic [16:0]    cmd_addr_i, usr_addr_o;
   logic [15:0]    cmd_wdata_i, usr_rdata_i, usr_wdata_o, rdata_o, got_wd;
   logic           usr_rd_o, usr_wr_o, usr_init_o, usr_loading_o, cmd_rdy_o, done_o, card_busy_o;
   logic           seen_rd, seen_wr, seen16, seenack, load_done;
   logic [16:0]    got_ad;
   pchb_space_type usr_space_o, got_sp;
   logic [31:0]    lfsr, rl;
   int             mismatches = 0, compares = 0, inits = 0, k;
   pchb_if bus_if ();
   pchb_card pchb_card_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .bus(bus_if), .usr_addr_o(usr_addr_o),
      .usr_space_o(usr_space_o), .usr_rd_o(usr_rd_o), .usr_wr_o(usr_wr_o), .usr_wdata_o(usr_wdata_o),
      .usr_rdata_i(usr_rdata_i), .usr_ready_i(usr_ready_i), .usr_init_o(usr_init_o),
      .usr_loading_o(usr_loading_o), .usr_load_done_i(load_done));
   pchb_host pchb_host_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .bus(bus_if), .cmd_vld_i(cmd_vld_i),
      .cmd_wr_i(cmd_wr_i), .cmd_io_i(cmd_io_i), .cmd_attr_i(cmd_attr_i), .cmd_lane_i(cmd_lane_i),
      .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i), .card_rst_i(card_rst_i), .cmd_rdy_o(cmd_rdy_o),
      .done_o(done_o), .rdata_o(rdata_o), .card_busy_o(card_busy_o));
   pchb_sva pchb_sva_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce1_n(bus_if.ce1_n), .ce2_n(bus_if.ce2_n),
      .reg_n(bus_if.reg_n), .oe_n(bus_if.oe_n), .we_n(bus_if.we_n), .iord_n(bus_if.iord_n),
      .iowr_n(bus_if.iowr_n), .reset(bus_if.reset), .iois16_n(bus_if.iois16_n), .inpack_n(bus_if.inpack_n),
      .wait_n(bus_if.wait_n), .host_interrupt_request(bus_if.host_interrupt_request),
      .hd_card_oe_hi(bus_if.hd_card_oe_hi), .hd_card_oe_lo(bus_if.hd_card_oe_lo));
   function automatic logic [31:0] nxt(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic pchb_space_type exp_sp(input logic io, attr);
      return io ? PCHB_SPACE_IO : (attr ? PCHB_SPACE_ATTR : PCHB_SPACE_COMMON);
   endfunction
   task automatic chk(input logic [15:0] got, exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic run(input logic wr, io, attr, input logic [1:0] lane);
      logic [15:0] m;
      int n;
      m = {{8{lane[1]}}, {8{lane[0]}}};
      chk(cmd_rdy_o, 1'b1);
      lfsr = nxt(lfsr);
      {seen_rd, seen_wr, seen16, seenack} = 4'h0;
      {cmd_wr_i, cmd_io_i, cmd_attr_i, cmd_lane_i} = {wr, io, attr, lane};
      cmd_addr_i = {1'b0, lfsr[15:0]};
      cmd_wdata_i = lfsr[31:16];
      usr_rdata_i = lfsr[23:8];
      cmd_vld_i = 1'b1;
      n = 0;
      do begin
         @(negedge sys_clk_i);
         n++;
      end while (done_o !== 1'b1 && n < 200);
      cmd_vld_i = 1'b0;
      // one edge with the command low before the next one starts
      @(negedge sys_clk_i);
      if (n >= 200) mismatches++;
      if (lane != 2'h0) chk(got_ad[15:0], cmd_addr_i[15:0]);
      chk(seen_wr, wr && lane != 2'h0);
      chk(seen_rd, !wr && lane != 2'h0);
      chk(seen16, io && lane != 2'h0);
      chk(seenack, io && !wr && lane != 2'h0);
      if (lane != 2'h0) chk(got_sp, exp_sp(io, attr));
      if (wr && lane != 2'h0) chk(got_wd & m, cmd_wdata_i & m);
      else if (lane != 2'h0) chk(rdata_o & m, usr_rdata_i & m);
   endtask
   // ready toggles on its own stream so wait lengths vary
   always @(negedge sys_clk_i) begin
      rl = nxt(rl);
      usr_ready_i = rl[0];
   end
   always @(posedge sys_clk_i) begin
      if (usr_wr_o) begin
         seen_wr <= 1'b1;
         got_wd <= usr_wdata_o;
         got_sp <= usr_space_o;
         got_ad <= usr_addr_o;
      end
      if (usr_rd_o) begin
         seen_rd <= 1'b1;
         got_sp <= usr_space_o;
         got_ad <= usr_addr_o;
      end
      if (!bus_if.iois16_n) seen16 <= 1'b1;
      if (!bus_if.inpack_n) seenack <= 1'b1;
      if (usr_init_o) inits <= inits + 1;
   end
   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      #400000;
      mismatches++;
      results;
   end
   initial begin
      {nrst_i, cmd_vld_i, card_rst_i, cmd_wr_i, cmd_io_i, cmd_attr_i, cmd_lane_i} = 8'h00;
      {cmd_addr_i, cmd_wdata_i, usr_rdata_i} = 49'h0;
      load_done = 1'b0;
      lfsr = 32'h5AA9;
      rl = 32'h5AA9;
      repeat (16) @(negedge sys_clk_i);
      nrst_i = 1'b1;
      for (k = 0; k < 100 && card_busy_o !== 1'b0; k++) @(negedge sys_clk_i);
      chk(card_busy_o, 1'b0);
      for (k = 0; k < 8; k++) run(k[0], k[1], k[2], 2'h3);
      for (k = 0; k < 40; k++) run(lfsr[0], lfsr[1], lfsr[2], lfsr[5:4]);
      k = inits;
      card_rst_i = 1'b1;
      @(negedge sys_clk_i);
      chk(cmd_rdy_o, 1'b0);
      card_rst_i = 1'b0;
      repeat (30) @(negedge sys_clk_i);
      chk(card_busy_o, 1'b1);
      chk(usr_loading_o, 1'b1);
      // early load finish from the user side ends the busy phase
      load_done = 1'b1;
      @(negedge sys_clk_i);
      load_done = 1'b0;
      @(negedge sys_clk_i);
      chk(card_busy_o, 1'b0);
      chk(usr_loading_o, 1'b0);
      repeat (150) if (card_busy_o !== 1'b0) @(negedge sys_clk_i);
      chk(16'(inits - k), 16'h0001);
      run(1'b0, 1'b0, 1'b1, 2'h3);
      results;
   end
endmodule // pc_card_host_bus_control_bench
